// file: rtl/cfg_engage_pkg.sv
package cfg_engage_pkg;

    // AXI4-Lite register map
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam logic CTRL_ENABLE_RESET = 1'b1;
    localparam int STATUS_PARKED_BIT = 0;
    localparam int STATUS_IO_CFG_BIT = 1;
    localparam int STATUS_HOLD_BIT = 2;
    localparam int STATUS_SCHEME_LSB = 4;
    localparam int STATUS_INSTR_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Synchroniser bundle bit positions
    localparam int SYNC_WIDTH = 9;
    localparam int SYNC_SCAN_CLOCK = 0;
    localparam int SYNC_UPDATE = 1;
    localparam int SYNC_TAP_RESET = 2;
    localparam int SYNC_REQ_N = 3;
    localparam int SYNC_SCHEME_LSB = 4;
    localparam int SYNC_INSTR_LSB = 6;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 9'h008;

    // Timing
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int RECONFIG_HOLD_NS = 500;
    localparam int HOLD_CYCLES_INT =
        (RECONFIG_HOLD_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
    localparam logic [7:0] HOLD_CYCLES = HOLD_CYCLES_INT[7:0];

    typedef enum logic [1:0] {
        PASSIVE_SERIAL_SCHEME = 2'h0,
        PASSIVE_PARALLEL_SCHEME = 2'h1,
        ACTIVE_SERIAL_SCHEME = 2'h2,
        ACTIVE_PARALLEL_SCHEME = 2'h3
    } scheme_type;

    typedef enum logic [2:0] {
        INSTR_BYPASS = 3'h0,
        INSTR_IO_CHAIN_RELOAD = 3'h1,
        INSTR_RECONFIG_PULSE = 3'h2,
        INSTR_CTRL_PARK = 3'h3,
        INSTR_CTRL_RESUME = 3'h4,
        INSTR_SCAN_PROGRAM = 3'h5,
        INSTR_SCAN_STARTUP = 3'h6,
        INSTR_OTHER = 3'h7
    } instr_type;

    typedef enum logic [2:0] {
        RS_IDLE = 3'b001,
        RS_HOLD = 3'b010,
        RS_START = 3'b100
    } recfg_state_type;

endpackage

// file: rtl/pin_sync_if.sv
`timescale 1ns/10ps
interface pin_sync_if;
    import cfg_engage_pkg::*;
    logic [SYNC_WIDTH-1:0] raw;
    logic [SYNC_WIDTH-1:0] clean;
    modport sync_side (input raw, output clean);
    modport user_side (output raw, input clean);
endinterface

// file: rtl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync (
    input wire logic i_clock,
    input wire logic i_rst_n,
    pin_sync_if.sync_side bus
);
    import cfg_engage_pkg::*;

    logic [SYNC_WIDTH-1:0] s1_q, s2_q, s3_q, clean_q;
    logic [SYNC_WIDTH-1:0] s1_d, s2_d, s3_d, clean_d;

    // A bit only moves once the second and third stage agree
    genvar g;
    generate
        for (g = 0; g < SYNC_WIDTH; g++) begin : gen_bit
            always_comb begin
                s1_d[g] = bus.raw[g];
                s2_d[g] = s1_q[g];
                s3_d[g] = s2_q[g];
                clean_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : clean_q[g];
            end
        end
    endgenerate

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            s1_q <= SYNC_RESET;
            s2_q <= SYNC_RESET;
            s3_q <= SYNC_RESET;
            clean_q <= SYNC_RESET;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            clean_q <= clean_d;
        end
    end

    assign bus.clean = clean_q;
endmodule

// file: rtl/cfg_engage_ctrl.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
module cfg_engage_ctrl (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_scan_clock,
    input wire logic i_instr_update,
    input wire logic [2:0] i_instr_code,
    input wire logic i_tap_reset_state,
    input wire logic i_reconfig_request_n,
    input wire logic [1:0] i_scheme_select_pins,
    input wire logic i_user_mode_reached,
    output logic o_ctrl_park,
    output logic o_ctrl_user_mode_go,
    output logic o_reconfig_start,
    output logic o_io_chain_reload,
    output logic o_user_io_oe_n,
    output logic o_config_status_out,
    output logic o_config_status_oe_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cfg_engage_pkg::*;

    pin_sync_if sync_bus ();

    assign sync_bus.raw = {i_instr_code, i_scheme_select_pins,
        i_reconfig_request_n, i_tap_reset_state, i_instr_update,
        i_scan_clock};

    pin_sync u_sync (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .bus(sync_bus.sync_side)
    );

    logic scan_clk_c, update_c, tap_reset_c, req_n_c;
    logic [1:0] scheme_c;
    logic [2:0] instr_c;
    assign scan_clk_c = sync_bus.clean[SYNC_SCAN_CLOCK];
    assign update_c = sync_bus.clean[SYNC_UPDATE];
    assign tap_reset_c = sync_bus.clean[SYNC_TAP_RESET];
    assign req_n_c = sync_bus.clean[SYNC_REQ_N];
    assign scheme_c = sync_bus.clean[SYNC_SCHEME_LSB +: 2];
    assign instr_c = sync_bus.clean[SYNC_INSTR_LSB +: 3];

    // Control state
    logic ctrl_enable_q;
    logic scan_clk_prev_q, scan_clk_prev_d;
    logic tap_reset_prev_q, tap_reset_prev_d;
    instr_type instr_q, instr_d;
    logic parked_q, parked_d;
    recfg_state_type rs_q, rs_d;
    logic [7:0] hold_cnt_q, hold_cnt_d;
    logic park_out_q, park_out_d;
    logic go_q, go_d;
    logic start_q, start_d;
    logic reload_q, reload_d;
    logic io_oe_n_q, io_oe_n_d;
    logic status_oe_n_q, status_oe_n_d;

    logic take, active_scheme, serial_active, trigger;
    instr_type new_instr;

    always_comb begin
        new_instr = instr_type'(instr_c);
        take = scan_clk_c && !scan_clk_prev_q && update_c && ctrl_enable_q;
        active_scheme = scheme_c[1];
        serial_active = scheme_c == ACTIVE_SERIAL_SCHEME;
        scan_clk_prev_d = scan_clk_c;
        tap_reset_prev_d = tap_reset_c;
        instr_d = instr_q;
        parked_d = parked_q;
        go_d = 1'b0;
        reload_d = 1'b0;
        trigger = 1'b0;
        if (take) begin
            instr_d = new_instr;
        end
        if (tap_reset_c) begin
            instr_d = INSTR_BYPASS;
        end
        if (take && new_instr == INSTR_IO_CHAIN_RELOAD) begin
            reload_d = 1'b1;
        end
        if (take && new_instr == INSTR_RECONFIG_PULSE) begin
            trigger = 1'b1;
        end
        if (take && new_instr == INSTR_CTRL_RESUME) begin
            trigger = 1'b1;
            if (parked_q) begin
                go_d = active_scheme;
            end
            parked_d = 1'b0;
        end
        // Reset entry re-engages only the serial controller
        if (tap_reset_c && !tap_reset_prev_q && serial_active) begin
            parked_d = 1'b0;
        end
        if (i_user_mode_reached && parked_q) begin
            parked_d = 1'b0;
            go_d = 1'b1;
        end
        // Set wins over any clear arriving in the same cycle
        if (take && new_instr == INSTR_CTRL_PARK && active_scheme) begin
            parked_d = 1'b1;
        end
        park_out_d = parked_d;
        // Request pin restarts configuration but never touches parked_d
        rs_d = rs_q;
        hold_cnt_d = hold_cnt_q;
        start_d = 1'b0;
        unique case (rs_q)
            RS_IDLE: begin
                if (trigger || !req_n_c) begin
                    rs_d = RS_HOLD;
                    hold_cnt_d = HOLD_CYCLES;
                end
            end
            RS_HOLD: begin
                if (hold_cnt_q != 8'h00) begin
                    hold_cnt_d = hold_cnt_q - 8'h01;
                end else if (req_n_c) begin
                    rs_d = RS_START;
                end
            end
            RS_START: begin
                start_d = 1'b1;
                rs_d = RS_IDLE;
            end
        endcase
        // Device reset ends any scan instruction in force
        if (rs_q == RS_START) begin
            instr_d = INSTR_BYPASS;
        end
        io_oe_n_d = instr_d == INSTR_IO_CHAIN_RELOAD;
        // Status is pulled low only by a reconfiguration hold
        status_oe_n_d = rs_d != RS_HOLD;
    end

    // AXI4-Lite slave
    logic awready_q, awready_d, wready_q, wready_d;
    logic aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [3:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic en_next;

    always_comb begin
        aw_have_d = aw_have_q;
        w_have_d = w_have_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        en_next = ctrl_enable_q;
        if (s_axi_awvalid && awready_q) begin
            aw_have_d = 1'b1;
            awaddr_d = s_axi_awaddr[3:0];
        end
        if (s_axi_wvalid && wready_q) begin
            w_have_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb0_d = s_axi_wstrb[0];
        end
        if (aw_have_q && w_have_q && !bvalid_q) begin
            aw_have_d = 1'b0;
            w_have_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = RESP_SLVERR;
            if (awaddr_q == CTRL_OFFSET) begin
                bresp_d = RESP_OKAY;
                if (wstrb0_q) begin
                    en_next = wdata_q[CTRL_ENABLE_BIT];
                end
            end else if (awaddr_q == STATUS_OFFSET) begin
                bresp_d = RESP_OKAY;
            end
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_have_d && !bvalid_d;
        wready_d = !w_have_d && !bvalid_d;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rdata_d = 32'h0000_0000;
            rresp_d = RESP_OKAY;
            if (s_axi_araddr[3:0] == CTRL_OFFSET) begin
                rdata_d[CTRL_ENABLE_BIT] = ctrl_enable_q;
            end else if (s_axi_araddr[3:0] == STATUS_OFFSET) begin
                rdata_d[STATUS_PARKED_BIT] = parked_q;
                rdata_d[STATUS_IO_CFG_BIT] = io_oe_n_q;
                rdata_d[STATUS_HOLD_BIT] = rs_q != RS_IDLE;
                rdata_d[STATUS_SCHEME_LSB +: 2] = scheme_c;
                rdata_d[STATUS_INSTR_LSB +: 3] = instr_q;
            end else begin
                rresp_d = RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        arready_d = !rvalid_d;
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_n) begin
            ctrl_enable_q <= CTRL_ENABLE_RESET;
            scan_clk_prev_q <= 1'b0;
            tap_reset_prev_q <= 1'b0;
            instr_q <= INSTR_BYPASS;
            parked_q <= 1'b0;
            rs_q <= RS_IDLE;
            hold_cnt_q <= 8'h00;
            park_out_q <= 1'b0;
            go_q <= 1'b0;
            start_q <= 1'b0;
            reload_q <= 1'b0;
            io_oe_n_q <= 1'b0;
            status_oe_n_q <= 1'b1;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else begin
            ctrl_enable_q <= en_next;
            scan_clk_prev_q <= scan_clk_prev_d;
            tap_reset_prev_q <= tap_reset_prev_d;
            instr_q <= instr_d;
            parked_q <= parked_d;
            rs_q <= rs_d;
            hold_cnt_q <= hold_cnt_d;
            park_out_q <= park_out_d;
            go_q <= go_d;
            start_q <= start_d;
            reload_q <= reload_d;
            io_oe_n_q <= io_oe_n_d;
            status_oe_n_q <= status_oe_n_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            aw_have_q <= aw_have_d;
            w_have_q <= w_have_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    assign o_ctrl_park = park_out_q;
    assign o_ctrl_user_mode_go = go_q;
    assign o_reconfig_start = start_q;
    assign o_io_chain_reload = reload_q;
    assign o_user_io_oe_n = io_oe_n_q;
    assign o_config_status_out = 1'b0;
    assign o_config_status_oe_n = status_oe_n_q;
    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rvalid = rvalid_q;
endmodule

// file: testbench/cfg_engage_ctrl_assertions.sv
`timescale 1ns/10ps
module cfg_engage_ctrl_assertions (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [1:0] i_scheme_select_pins,
    input wire logic i_user_mode_reached,
    input wire logic o_ctrl_park,
    input wire logic o_ctrl_user_mode_go,
    input wire logic o_reconfig_start,
    input wire logic o_io_chain_reload,
    input wire logic o_user_io_oe_n,
    input wire logic o_config_status_out,
    input wire logic o_config_status_oe_n,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import cfg_engage_pkg::*;
    logic [15:0] lowc_q;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Length of the current low drive on the status pin
    always_ff @(posedge i_clock) begin
        if (!i_rst_n || o_config_status_oe_n) lowc_q <= 16'h0000;
        else lowc_q <= lowc_q + 16'h0001;
    end
    hold_min_a: assert property ($rose(o_config_status_oe_n) |->
        $past(lowc_q) >= 16'h0064) else $error("status hold too short");
    // Start pulse trails the status release by one cycle
    start_release_a: assert property (o_reconfig_start |->
        o_config_status_oe_n && !$past(o_config_status_oe_n, 2))
        else $error("start without status release");
    start_once_a: assert property (o_reconfig_start |=>
        !o_reconfig_start) else $error("start pulse too long");
    io_status_a: assert property (o_io_chain_reload |->
        o_config_status_oe_n [*4]) else $error("reload drove status");
    status_data_a: assert property (o_config_status_out == 1'b0)
        else $error("status data not low");
    io_tristate_a: assert property (o_io_chain_reload |->
        ##[0:1] o_user_io_oe_n) else $error("user io not tristated");
    park_passive_a: assert property ($rose(o_ctrl_park) |->
        i_scheme_select_pins[1]) else $error("park in passive scheme");
    user_mode_go_a: assert property (i_user_mode_reached && o_ctrl_park
        && i_scheme_select_pins[1] |=> o_ctrl_user_mode_go && !o_ctrl_park)
        else $error("no re-engage on user mode");
    parallel_wake_a: assert property ($fell(o_ctrl_park) &&
        i_scheme_select_pins == ACTIVE_PARALLEL_SCHEME |->
        o_ctrl_user_mode_go) else $error("parallel unparked wrongly");
    go_clears_a: assert property (o_ctrl_user_mode_go |-> !o_ctrl_park)
        else $error("go with park still set");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    cover property (o_reconfig_start);
    cover property (o_ctrl_user_mode_go);
    cover property (o_io_chain_reload);
endmodule

bind cfg_engage_ctrl cfg_engage_ctrl_assertions cfg_engage_ctrl_assertions_inst (
    .i_clock, .i_rst_n, .i_scheme_select_pins, .i_user_mode_reached,
    .o_ctrl_park, .o_ctrl_user_mode_go, .o_reconfig_start,
    .o_io_chain_reload, .o_user_io_oe_n, .o_config_status_out,
    .o_config_status_oe_n, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);

// file: testbench/scan_host_model.sv
`timescale 1ns/10ps
module scan_host_model (
    input wire logic i_reconfig_request_n,
    output logic o_scan_clock,
    output logic o_instr_update,
    output logic [2:0] o_instr_code,
    output logic o_tap_reset_state
);
    import cfg_engage_pkg::*;
    realtime t_restart = 0.0;
    initial begin
        o_scan_clock = 1'b0;
        o_instr_update = 1'b0;
        o_instr_code = 3'h0;
        o_tap_reset_state = 1'b0;
    end
    always @(posedge i_reconfig_request_n) t_restart = $realtime;
    // Scan clock only runs inside a frame
    task issue(input logic [2:0] c);
        if (c == INSTR_IO_CHAIN_RELOAD) begin
            wait (i_reconfig_request_n === 1'b1);
            while ($realtime - t_restart < 230000.0) #1000;
        end
        o_instr_code = c;
        o_instr_update = 1'b1;
        #32 o_scan_clock = 1'b1;
        #32 o_scan_clock = 1'b0;
        o_instr_update = 1'b0;
        o_instr_code = ~c;
        if (c == INSTR_RECONFIG_PULSE || c == INSTR_CTRL_RESUME)
            t_restart = $realtime;
    endtask
    task tap_reset;
        o_tap_reset_state = 1'b1;
        #200 o_tap_reset_state = 1'b0;
    endtask
endmodule

// file: testbench/tb_jtag_config_engage_control.sv
`timescale 1ns/10ps
module tb_jtag_config_engage_control;
    import cfg_engage_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_reconfig_request_n = 1'b1;
    logic [1:0] i_scheme_select_pins = 2'h0;
    logic i_user_mode_reached = 1'b0;
    logic i_scan_clock, i_instr_update, i_tap_reset_state;
    logic [2:0] i_instr_code;
    logic o_ctrl_park, o_ctrl_user_mode_go, o_reconfig_start;
    logic o_io_chain_reload, o_user_io_oe_n;
    logic o_config_status_out, o_config_status_oe_n;
    logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
    logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [33:0] q[$];
    logic [15:0] lf = 16'h0B2A;
    logic [31:0] bad;
    int fails = 0, n_checks = 0, n_start = 0, n_go = 0, n_rel = 0;
    int es = 0, eg = 0;
    always #2.5 i_clock = ~i_clock;

    cfg_engage_ctrl cfg_engage_ctrl_inst (
        .i_clock, .i_rst_n, .i_scan_clock, .i_instr_update, .i_instr_code,
        .i_tap_reset_state, .i_reconfig_request_n, .i_scheme_select_pins,
        .i_user_mode_reached, .o_ctrl_park, .o_ctrl_user_mode_go,
        .o_reconfig_start, .o_io_chain_reload, .o_user_io_oe_n,
        .o_config_status_out, .o_config_status_oe_n, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
    );
    scan_host_model scan_host_model_inst (
        .i_reconfig_request_n,
        .o_scan_clock(i_scan_clock),
        .o_instr_update(i_instr_update),
        .o_instr_code(i_instr_code),
        .o_tap_reset_state(i_tap_reset_state)
    );

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task ck(input logic [33:0] g, input logic [33:0] e);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // Expected answer is queued; the monitor compares when it shows up
    task axi(input logic w, input logic [31:0] a, d, input logic [33:0] e);
        int n;
        q.push_back(e);
        // Random late ready makes the slave hold its answer
        lf = lfsr(lf);
        if (w) begin
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= lf[0];
        end else begin
            s_axi_araddr <= a;
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= lf[0];
        end
        for (n = 0; n < 50; n++) begin
            @(posedge i_clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if ((s_axi_bvalid && s_axi_bready) ||
                (s_axi_rvalid && s_axi_rready)) break;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        if (n == 50) fails++;
        @(posedge i_clock);
    endtask
    task sch(input logic [1:0] s);
        i_scheme_select_pins <= s;
        cyc(10);
    endtask
    // Long settle covers the hold and start of any reconfiguration
    task op(input logic [2:0] c);
        scan_host_model_inst.issue(c);
        cyc(250);
    endtask
    task final_report;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    always @(posedge i_clock) begin
        if (s_axi_bvalid && s_axi_bready) begin
            if (q.size() == 0) fails++;
            else ck({s_axi_bresp, 32'h0}, q.pop_front());
        end
        if (s_axi_rvalid && s_axi_rready) begin
            if (q.size() == 0) fails++;
            else ck({s_axi_rresp, s_axi_rdata}, q.pop_front());
        end
        if (o_reconfig_start === 1'b1) n_start++;
        if (o_ctrl_user_mode_go === 1'b1) n_go++;
        if (o_io_chain_reload === 1'b1) n_rel++;
    end
    initial begin
        #400000;
        fails++;
        final_report;
    end
    initial begin
        cyc(2);
        i_rst_n <= 1'b1;
        cyc(4);
        lf = lfsr(lf);
        bad = 32'({lf[11:0], 4'h8});
        axi(0, 32'(CTRL_OFFSET), 32'h0, {RESP_OKAY, 32'h1});
        axi(0, 32'(STATUS_OFFSET), 32'h0, {RESP_OKAY, 32'h0});
        axi(1, bad, 32'h1, {RESP_SLVERR, 32'h0});
        axi(0, bad, 32'h0, {RESP_SLVERR, 32'h0});
        s_axi_wstrb <= 4'hE;
        axi(1, 32'(CTRL_OFFSET), 32'h0, {RESP_OKAY, 32'h0});
        s_axi_wstrb <= 4'hF;
        axi(0, 32'(CTRL_OFFSET), 32'h0, {RESP_OKAY, 32'h1});
        $display("test registers done");
        sch(ACTIVE_SERIAL_SCHEME);
        axi(1, 32'(CTRL_OFFSET), 32'h0, {RESP_OKAY, 32'h0});
        op(INSTR_CTRL_PARK);
        ck(34'(o_ctrl_park), 34'h0);
        lf = lfsr(lf);
        axi(1, 32'(CTRL_OFFSET), {lf, lf} | 32'h1, {RESP_OKAY, 32'h0});
        axi(0, 32'(CTRL_OFFSET), 32'h0, {RESP_OKAY, 32'h1});
        op(INSTR_CTRL_PARK);
        ck(34'(o_ctrl_park), 34'h1);
        op(INSTR_IO_CHAIN_RELOAD);
        ck(34'(n_rel), 34'h1);
        ck(34'(o_user_io_oe_n), 34'h1);
        ck(34'(o_config_status_oe_n), 34'h1);
        axi(0, 32'(STATUS_OFFSET), 32'h0, {RESP_OKAY, 32'h123});
        scan_host_model_inst.tap_reset();
        cyc(12);
        ck(34'(o_ctrl_park), 34'h0);
        ck(34'(o_user_io_oe_n), 34'h0);
        axi(0, 32'(STATUS_OFFSET), 32'h0, {RESP_OKAY, 32'h20});
        $display("test active serial done");
        sch(ACTIVE_PARALLEL_SCHEME);
        op(INSTR_CTRL_PARK);
        i_reconfig_request_n <= 1'b0;
        cyc(120);
        ck(34'({o_config_status_oe_n, o_config_status_out}), 34'h0);
        i_reconfig_request_n <= 1'b1;
        cyc(250);
        es++;
        ck(34'(n_start), 34'(es));
        ck(34'(o_ctrl_park), 34'h1);
        scan_host_model_inst.tap_reset();
        cyc(12);
        ck(34'(o_ctrl_park), 34'h1);
        op(INSTR_CTRL_RESUME);
        es++;
        eg++;
        ck(34'(o_ctrl_park), 34'h0);
        ck(34'(n_go), 34'(eg));
        ck(34'(n_start), 34'(es));
        op(INSTR_CTRL_PARK);
        op(INSTR_SCAN_PROGRAM);
        op(INSTR_SCAN_STARTUP);
        i_user_mode_reached <= 1'b1;
        cyc(1);
        i_user_mode_reached <= 1'b0;
        cyc(5);
        eg++;
        ck(34'(o_ctrl_park), 34'h0);
        ck(34'(n_go), 34'(eg));
        scan_host_model_inst.tap_reset();
        cyc(12);
        $display("test active parallel done");
        sch(PASSIVE_SERIAL_SCHEME);
        op(INSTR_CTRL_PARK);
        ck(34'(o_ctrl_park), 34'h0);
        op(INSTR_CTRL_RESUME);
        es++;
        ck(34'(n_start), 34'(es));
        ck(34'(n_go), 34'(eg));
        op(INSTR_RECONFIG_PULSE);
        es++;
        ck(34'(n_start), 34'(es));
        $display("test passive done");
        final_report;
    end
endmodule
